/* src/oscillogram_playback_sim.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - A completed serial upload enters simulation mode.
// - After upload, stay in mode until an exit condition.
// - A cancel pulse in simulation mode leaves the mode.
// - Playback starts only in simulation mode on an enabled trigger.
// - With digital trigger YES, a start pulse begins playback.
// - With time trigger YES, playback begins when clock equals record time.
// - Mode is left five seconds after playback ends.
// - Entry pulse re-enters mode with the latest stored record.
// - During playback, memory samples replace converter samples.
// - Recording keeps taking live samples during playback.
// - Input simulation YES replaces physical inputs with record logic signals during playback.
// - Trip/close enable NO blocks the switching outputs in simulation mode.
// - Auxiliary enable NO blocks the auxiliary outputs in simulation mode.
// - Mode indication is high throughout simulation mode.
// - Started indication is high only while playback runs.
// - Loaded indication is high after a record upload.
// - All five settings are yes/no and reset to no.
module oscillogram_playback_sim
   import osc_sim_pkg::*;
#(
   parameter int SAMPLE_W = 16,
   parameter int DIN_W = 8,
   parameter int TIME_W = 32,
   parameter int DEPTH = 1024,
   parameter int TRIP_W = 2,
   parameter int AUX_W = 8,
   parameter int HOLDOFF_CYCLES = HOLDOFF_CYCLES_DEF
) (
   input wire logic CLK, // System clock, 10 MHz.
   input wire logic RST_N, // Synchronous reset, active low.
   input wire logic [4:0] AVS_ADDRESS, // Register byte address.
   input wire logic AVS_READ, // Read request.
   input wire logic AVS_WRITE, // Write request.
   input wire logic [31:0] AVS_WRITEDATA, // Write data.
   input wire logic [3:0] AVS_BYTEENABLE, // Byte lanes.
   output logic [31:0] AVS_READDATA, // Read data.
   output logic AVS_WAITREQUEST, // Stall of the request.
   output logic IRQ, // Level interrupt.
   input wire logic REC_WR_VALID, // Record word present.
   output logic REC_WR_READY, // Record word taken.
   input wire logic [DIN_W+SAMPLE_W-1:0] REC_WR_DATA, // Logic bits over sample.
   input wire logic REC_WR_LAST, // Last word of a record.
   input wire logic REC_WR_UPLOAD, // Record came over the serial port.
   input wire logic [TIME_W-1:0] REC_WR_TIME, // Record trigger time, with last.
   input wire logic [TIME_W-1:0] RTC_TIME, // Real-time clock.
   input wire logic SIM_MODE_ENTRY_IN, // Mode-entry input.
   input wire logic PLAYBACK_START_IN, // Playback start input.
   input wire logic SIM_CANCEL_IN, // Cancellation input.
   input wire logic ADC_VALID, // Converter sample strobe.
   input wire logic [SAMPLE_W-1:0] ADC_SAMPLE, // Converter sample.
   output logic PROC_VALID, // Sample strobe to processing.
   output logic [SAMPLE_W-1:0] PROC_SAMPLE, // Sample to processing.
   output logic RECORDER_VALID, // Sample strobe to the waveform recorder.
   output logic [SAMPLE_W-1:0] RECORDER_SAMPLE, // Live sample to the recorder.
   input wire logic [DIN_W-1:0] DIN_PHYS, // Physical digital inputs.
   output logic [DIN_W-1:0] DIN_OUT, // Digital inputs seen by the logic.
   input wire logic [TRIP_W-1:0] TRIP_CLOSE_REQ, // Switching output requests.
   output logic [TRIP_W-1:0] TRIP_CLOSE_OUT, // Switching output drives.
   input wire logic [AUX_W-1:0] AUX_REQ, // Auxiliary output requests.
   output logic [AUX_W-1:0] AUX_OUT, // Auxiliary output drives.
   output logic RECORD_LOADED_OUT, // Record uploaded for simulation.
   output logic SIM_MODE_ACTIVE_OUT, // In simulation mode.
   output logic PLAYBACK_STARTED_OUT // Playback run in progress.
);
   localparam int AW = $clog2(DEPTH);
   localparam int WORD_W = DIN_W + SAMPLE_W;

   // ==========
   // Elaboration checks.
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("Bad DEPTH");
      end
      if (HOLDOFF_CYCLES < 1 || SAMPLE_W < 1 || DIN_W < 1 || TIME_W > 32) begin : g_bad_w
         $error("Bad width or hold-off");
      end
   endgenerate

   function automatic logic is_reg(input logic [4:0] addr, input logic [4:0] ofs);
      return addr[4:2] == ofs[4:2];
   endfunction

   sim_state_t state;
   logic [SET_W-1:0] settings;
   logic [EV_W-1:0] evt_status;
   logic [EV_W-1:0] evt_enable;
   logic [EV_W-1:0] events;
   logic ack;
   logic bus_wr;
   logic [AW-1:0] wr_ptr;
   logic [AW:0] rec_len;
   logic [TIME_W-1:0] rec_time;
   logic rec_valid;
   logic loaded;
   logic [AW-1:0] rd_ptr;
   logic rd_en;
   logic rd_last;
   logic rd_pending;
   logic [WORD_W-1:0] rd_data;
   logic [31:0] hold_cnt;
   logic wr_take;
   logic upload_done;
   logic start_trig;
   logic cancel;
   logic [2:0] pin_now;
   logic [2:0] pin_prev;
   logic [2:0] pin_rise;

   // ==========
   // Edge detection of the three control inputs.
   assign pin_now = {SIM_CANCEL_IN, PLAYBACK_START_IN, SIM_MODE_ENTRY_IN};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_edge
         always_ff @(posedge CLK) begin
            if (!RST_N) begin
               pin_prev[gi] <= 1'b0;
            end else begin
               pin_prev[gi] <= pin_now[gi];
            end
         end
         assign pin_rise[gi] = pin_now[gi] & ~pin_prev[gi];
      end
   endgenerate

   assign cancel = pin_rise[2] && state != S_IDLE;
   assign start_trig = (settings[SET_DIG_TRIG] && pin_rise[1])
      || (settings[SET_TIME_TRIG] && RTC_TIME == rec_time);

   // ==========
   // Avalon-MM slave: every access waits exactly one cycle.
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
   assign bus_wr = AVS_WRITE & ack & AVS_BYTEENABLE[0];

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ack <= 1'b0;
      end else begin
         ack <= (AVS_READ | AVS_WRITE) & ~ack;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_READ && !ack) begin
         AVS_READDATA <= 32'h0000_0000;
         if (is_reg(AVS_ADDRESS, OFS_SETTINGS)) begin
            AVS_READDATA[SET_W-1:0] <= settings;
         end else if (is_reg(AVS_ADDRESS, OFS_STATE)) begin
            AVS_READDATA[ST_SIM_MODE] <= state != S_IDLE;
            AVS_READDATA[ST_PLAYING] <= state == S_PLAYING;
            AVS_READDATA[ST_LOADED] <= loaded;
            AVS_READDATA[ST_HOLDOFF] <= state == S_HOLDOFF;
            AVS_READDATA[ST_REC_VALID] <= rec_valid;
         end else if (is_reg(AVS_ADDRESS, OFS_EVT_STATUS)) begin
            AVS_READDATA[EV_W-1:0] <= evt_status;
         end else if (is_reg(AVS_ADDRESS, OFS_EVT_ENABLE)) begin
            AVS_READDATA[EV_W-1:0] <= evt_enable;
         end else if (is_reg(AVS_ADDRESS, OFS_REC_LEN)) begin
            AVS_READDATA[AW:0] <= rec_len;
         end else if (is_reg(AVS_ADDRESS, OFS_REC_TIME)) begin
            AVS_READDATA[TIME_W-1:0] <= rec_time;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         settings <= SETTINGS_RESET;
      end else if (bus_wr && is_reg(AVS_ADDRESS, OFS_SETTINGS)) begin
         settings <= AVS_WRITEDATA[SET_W-1:0];
      end
   end

   // ==========
   // Sticky events, write-one-to-clear; a new event wins over a clear.
   assign events[EV_UPLOADED] = upload_done;
   assign events[EV_PLAY_START] = state == S_ARMED && start_trig && rec_len != '0;
   assign events[EV_PLAY_DONE] = state == S_PLAYING && rd_en && rd_last;
   assign events[EV_SIM_EXIT] = cancel
      || (state == S_HOLDOFF && hold_cnt == 32'(HOLDOFF_CYCLES - 1));

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         evt_status <= EVT_RESET;
      end else if (bus_wr && is_reg(AVS_ADDRESS, OFS_EVT_CLEAR)) begin
         evt_status <= (evt_status & ~AVS_WRITEDATA[EV_W-1:0]) | events;
      end else begin
         evt_status <= evt_status | events;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         evt_enable <= EVT_RESET;
      end else if (bus_wr && is_reg(AVS_ADDRESS, OFS_EVT_ENABLE)) begin
         evt_enable <= AVS_WRITEDATA[EV_W-1:0];
      end
   end

   assign IRQ = |(evt_status & evt_enable);

   // ==========
   // Record loading; the store is locked while it is being played.
   assign REC_WR_READY = state != S_PLAYING;
   assign wr_take = REC_WR_VALID && REC_WR_READY;
   assign upload_done = wr_take && REC_WR_LAST && REC_WR_UPLOAD;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         wr_ptr <= '0;
         rec_len <= '0;
         rec_time <= '0;
         rec_valid <= 1'b0;
      end else if (wr_take) begin
         if (REC_WR_LAST || wr_ptr == AW'(DEPTH - 1)) begin
            wr_ptr <= '0;
            rec_len <= {1'b0, wr_ptr} + (AW + 1)'(1);
            rec_time <= REC_WR_TIME;
            rec_valid <= 1'b1;
         end else begin
            wr_ptr <= wr_ptr + AW'(1);
         end
      end
   end

   // ==========
   // Mode sequencer.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state <= S_IDLE;
      end else if (upload_done) begin
         state <= S_ARMED;
      end else if (cancel) begin
         state <= S_IDLE;
      end else begin
         case (state)
            S_IDLE: begin
               if (pin_rise[0] && rec_valid) begin
                  state <= S_ARMED;
               end
            end
            S_ARMED: begin
               if (events[EV_PLAY_START]) begin
                  state <= S_PLAYING;
               end
            end
            S_PLAYING: begin
               if (events[EV_PLAY_DONE]) begin
                  state <= S_HOLDOFF;
               end
            end
            S_HOLDOFF: begin
               if (events[EV_SIM_EXIT]) begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N || state != S_HOLDOFF) begin
         hold_cnt <= 32'h0000_0000;
      end else begin
         hold_cnt <= hold_cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N || cancel || events[EV_SIM_EXIT]) begin
         loaded <= 1'b0;
      end else if (upload_done) begin
         loaded <= 1'b1;
      end
   end

   // ==========
   // Playback: one record word per converter strobe.
   assign rd_en = state == S_PLAYING && ADC_VALID;
   assign rd_last = {1'b0, rd_ptr} == rec_len - (AW + 1)'(1);

   always_ff @(posedge CLK) begin
      if (!RST_N || state != S_PLAYING) begin
         rd_ptr <= '0;
      end else if (rd_en) begin
         rd_ptr <= rd_ptr + AW'(1);
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rd_pending <= 1'b0;
      end else begin
         rd_pending <= rd_en;
      end
   end

   record_mem #(
      .WORD_W(WORD_W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_mem (
      .CLK(CLK),
      .wr_en(wr_take),
      .wr_addr(wr_ptr),
      .wr_data(REC_WR_DATA),
      .rd_en(rd_en),
      .rd_addr(rd_ptr),
      .rd_data(rd_data)
   );

   // ==========
   // Sample routing toward processing and the waveform recorder.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         PROC_VALID <= 1'b0;
         PROC_SAMPLE <= '0;
      end else if (rd_pending) begin
         PROC_VALID <= 1'b1;
         PROC_SAMPLE <= rd_data[SAMPLE_W-1:0];
      end else begin
         PROC_VALID <= ADC_VALID && state != S_PLAYING;
         PROC_SAMPLE <= ADC_SAMPLE;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RECORDER_VALID <= 1'b0;
         RECORDER_SAMPLE <= '0;
      end else begin
         RECORDER_VALID <= ADC_VALID;
         RECORDER_SAMPLE <= ADC_SAMPLE;
      end
   end

   // ==========
   // Digital input substitution and output masking.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         DIN_OUT <= '0;
      end else if (settings[SET_DIN_SIM] && rd_pending) begin
         DIN_OUT <= rd_data[WORD_W-1:SAMPLE_W];
      end else if (settings[SET_DIN_SIM] && state == S_PLAYING) begin
         DIN_OUT <= DIN_OUT;
      end else begin
         DIN_OUT <= DIN_PHYS;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         TRIP_CLOSE_OUT <= '0;
      end else if (state != S_IDLE && !settings[SET_TRIP_CLOSE_EN]) begin
         TRIP_CLOSE_OUT <= '0;
      end else begin
         TRIP_CLOSE_OUT <= TRIP_CLOSE_REQ;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         AUX_OUT <= '0;
      end else if (state != S_IDLE && !settings[SET_AUX_EN]) begin
         AUX_OUT <= '0;
      end else begin
         AUX_OUT <= AUX_REQ;
      end
   end

   // ==========
   // Indications.
   assign SIM_MODE_ACTIVE_OUT = state != S_IDLE;
   assign PLAYBACK_STARTED_OUT = state == S_PLAYING;
   assign RECORD_LOADED_OUT = loaded;
endmodule
`default_nettype wire

/* src/osc_sim_pkg.sv */
// ==========
// Shared constants of the oscillogram playback simulator.
package osc_sim_pkg;

   // ==========
   // Register byte offsets.
   localparam logic [4:0] OFS_SETTINGS = 5'h00;
   localparam logic [4:0] OFS_STATE = 5'h04;
   localparam logic [4:0] OFS_EVT_STATUS = 5'h08;
   localparam logic [4:0] OFS_EVT_CLEAR = 5'h0C;
   localparam logic [4:0] OFS_EVT_ENABLE = 5'h10;
   localparam logic [4:0] OFS_REC_LEN = 5'h14;
   localparam logic [4:0] OFS_REC_TIME = 5'h18;

   // ==========
   // Setting bit positions; every setting is YES=1 / NO=0.
   localparam int SET_DIG_TRIG = 0;
   localparam int SET_TIME_TRIG = 1;
   localparam int SET_DIN_SIM = 2;
   localparam int SET_TRIP_CLOSE_EN = 3;
   localparam int SET_AUX_EN = 4;
   localparam int SET_W = 5;
   localparam logic [SET_W-1:0] SETTINGS_RESET = 5'h00;

   // ==========
   // State register bit positions.
   localparam int ST_SIM_MODE = 0;
   localparam int ST_PLAYING = 1;
   localparam int ST_LOADED = 2;
   localparam int ST_HOLDOFF = 3;
   localparam int ST_REC_VALID = 4;

   // ==========
   // Event bit positions, shared by status, clear and enable.
   localparam int EV_UPLOADED = 0;
   localparam int EV_PLAY_START = 1;
   localparam int EV_PLAY_DONE = 2;
   localparam int EV_SIM_EXIT = 3;
   localparam int EV_W = 4;
   localparam logic [EV_W-1:0] EVT_RESET = 4'h0;

   // ==========
   // Timing: exit delay after the end of playback.
   localparam longint CLK_HZ = 10_000_000;
   localparam longint HOLDOFF_TIME_MS = 5000;
   localparam int HOLDOFF_CYCLES_DEF = int'(HOLDOFF_TIME_MS * CLK_HZ / 1000);

   // ==========
   // Simulation mode states.
   typedef enum logic [1:0] {
      S_IDLE,
      S_ARMED,
      S_PLAYING,
      S_HOLDOFF
   } sim_state_t;

endpackage

/* src/record_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Record store: one write port, one read port with registered data.
module record_mem #(
   parameter int WORD_W = 24,
   parameter int DEPTH = 1024,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic CLK, // System clock.
   input wire logic wr_en, // Write strobe.
   input wire logic [AW-1:0] wr_addr, // Write address.
   input wire logic [WORD_W-1:0] wr_data, // Write data.
   input wire logic rd_en, // Read strobe.
   input wire logic [AW-1:0] rd_addr, // Read address.
   output logic [WORD_W-1:0] rd_data // Read data, one cycle after rd_en.
);
   logic [WORD_W-1:0] mem [DEPTH];

   always_ff @(posedge CLK) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge CLK) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule
`default_nettype wire

/* tb/oscillogram_playback_sim_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker of the playback simulator.
module osc_playback_checker #(
   parameter int SAMPLE_W = 16,
   parameter int DIN_W = 8,
   parameter int TRIP_W = 2,
   parameter int AUX_W = 8,
   parameter int HOLDOFF_CYCLES = 20
) (
   input wire logic CLK, // Clock.
   input wire logic RST_N, // Reset.
   input wire logic AVS_READ, // Read.
   input wire logic AVS_WRITE, // Write.
   input wire logic AVS_WAITREQUEST, // Stall.
   input wire logic REC_WR_VALID, // Word present.
   input wire logic REC_WR_READY, // Word taken.
   input wire logic REC_WR_LAST, // Last word.
   input wire logic REC_WR_UPLOAD, // Serial upload.
   input wire logic SIM_CANCEL_IN, // Cancel.
   input wire logic ADC_VALID, // Live strobe.
   input wire logic [SAMPLE_W-1:0] ADC_SAMPLE, // Live sample.
   input wire logic RECORDER_VALID, // Recorder strobe.
   input wire logic [SAMPLE_W-1:0] RECORDER_SAMPLE, // Recorder sample.
   input wire logic [DIN_W-1:0] DIN_PHYS, // Physical inputs.
   input wire logic [DIN_W-1:0] DIN_OUT, // Inputs seen.
   input wire logic [TRIP_W-1:0] TRIP_CLOSE_REQ, // Switching requests.
   input wire logic [TRIP_W-1:0] TRIP_CLOSE_OUT, // Switching drives.
   input wire logic [AUX_W-1:0] AUX_REQ, // Auxiliary requests.
   input wire logic [AUX_W-1:0] AUX_OUT, // Auxiliary drives.
   input wire logic SIM_MODE_ACTIVE_OUT, // Mode shown.
   input wire logic PLAYBACK_STARTED_OUT, // Playing shown.
   input wire logic RECORD_LOADED_OUT // Loaded shown.
);
   localparam int HO_LO = HOLDOFF_CYCLES - 2;
   localparam int HO_HI = HOLDOFF_CYCLES + 3;
   logic pb_q;
   logic after_play;
   int unsigned hold_cnt;
   logic up_done;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   assign up_done = REC_WR_VALID && REC_WR_READY && REC_WR_LAST && REC_WR_UPLOAD;
   // ==========
   // Counts the cycles spent in mode after a playback run ends.
   always_ff @(posedge CLK) begin
      pb_q <= PLAYBACK_STARTED_OUT;
   end
   always_ff @(posedge CLK) begin
      if (!RST_N || !SIM_MODE_ACTIVE_OUT) begin
         after_play <= 1'b0;
      end else if (pb_q && !PLAYBACK_STARTED_OUT) begin
         after_play <= 1'b1;
      end
   end
   always_ff @(posedge CLK) begin
      if (!RST_N || !after_play) begin
         hold_cnt <= 0;
      end else begin
         hold_cnt <= hold_cnt + 1;
      end
   end
   sequence s_upload_done;
      up_done;
   endsequence
   sequence s_mode_shown;
      ##[1:2] (SIM_MODE_ACTIVE_OUT && RECORD_LOADED_OUT);
   endsequence
   chk_upload_enters_mode: assert property (s_upload_done |-> s_mode_shown)
      else $error("no mode on upload");
   chk_cancel_leaves: assert property (SIM_MODE_ACTIVE_OUT && $rose(SIM_CANCEL_IN) && !up_done
      |-> ##[1:2] !SIM_MODE_ACTIVE_OUT) else $error("cancel ignored");
   chk_start_in_mode: assert property ($rose(PLAYBACK_STARTED_OUT) |-> $past(SIM_MODE_ACTIVE_OUT))
      else $error("start outside mode");
   chk_play_shows_mode: assert property (PLAYBACK_STARTED_OUT |-> SIM_MODE_ACTIVE_OUT)
      else $error("play without mode");
   chk_holdoff_late: assert property (after_play |-> hold_cnt < HO_HI)
      else $error("hold-off too long");
   chk_holdoff_early: assert property ($fell(SIM_MODE_ACTIVE_OUT) && after_play |-> hold_cnt >= HO_LO)
      else $error("hold-off too short");
   chk_pass_outside: assert property (!SIM_MODE_ACTIVE_OUT [*3] |-> DIN_OUT == $past(DIN_PHYS)
      && TRIP_CLOSE_OUT == $past(TRIP_CLOSE_REQ) && AUX_OUT == $past(AUX_REQ))
      else $error("no pass-through");
   chk_recorder_live: assert property (ADC_VALID |=> RECORDER_VALID && RECORDER_SAMPLE == $past(ADC_SAMPLE))
      else $error("recorder lost sample");
   chk_stream_stall: assert property (PLAYBACK_STARTED_OUT |-> !REC_WR_READY)
      else $error("words taken in playback");
   chk_bus_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus wait too long");
endmodule
bind oscillogram_playback_sim osc_playback_checker #(.SAMPLE_W(SAMPLE_W), .DIN_W(DIN_W),
   .TRIP_W(TRIP_W), .AUX_W(AUX_W), .HOLDOFF_CYCLES(HOLDOFF_CYCLES)) osc_playback_checker_i (
   .CLK, .RST_N, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .REC_WR_VALID, .REC_WR_READY,
   .REC_WR_LAST, .REC_WR_UPLOAD, .SIM_CANCEL_IN, .ADC_VALID, .ADC_SAMPLE, .RECORDER_VALID,
   .RECORDER_SAMPLE, .DIN_PHYS, .DIN_OUT, .TRIP_CLOSE_REQ, .TRIP_CLOSE_OUT, .AUX_REQ, .AUX_OUT,
   .SIM_MODE_ACTIVE_OUT, .PLAYBACK_STARTED_OUT, .RECORD_LOADED_OUT);
`default_nettype wire

/* tb/osc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host tool that uploads a record word by word.
module osc_host_model (
   input wire logic clk, // Clock.
   input wire logic ready, // Word taken.
   output logic valid, // Word present.
   output logic [23:0] data, // Logic bits over sample.
   output logic last, // Last word.
   output logic upload, // Serial upload.
   output logic [31:0] rec_time // Trigger time.
);
   initial begin
      valid = 1'b0;
      data = 24'h00_0000;
      last = 1'b0;
      upload = 1'b0;
      rec_time = 32'h0000_0000;
   end
   // Gaps of idle cycles model a slow host.
   task automatic send(input int n, input logic up, input logic [31:0] t, input int gap);
      @(posedge clk);
      for (int i = 0; i < n; i++) begin
         valid <= 1'b1;
         data <= {8'hC0 + 8'(i), 16'h1000 + 16'(i)};
         last <= (i == n - 1);
         upload <= up;
         rec_time <= t;
         do @(posedge clk); while (ready !== 1'b1);
         if (gap > 0 || i == n - 1) begin
            valid <= 1'b0;
            last <= 1'b0;
            data <= ~data;
            repeat (gap) @(posedge clk);
         end
      end
   endtask
endmodule
`default_nettype wire

/* tb/oscillogram_playback_sim_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module oscillogram_playback_sim_bench;
   import osc_sim_pkg::*;
   localparam int HO = 20;
   logic clk = 1'b0;
   logic rst_n, avs_read, avs_write, avs_waitrequest, irq, rec_valid, rec_ready, rec_last;
   logic rec_upload, adc_valid, proc_valid, recorder_valid, loaded, sim, pb;
   logic [4:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rec_time, rtc_time, rd;
   logic [23:0] rec_data;
   logic [2:0] ctl;
   logic [15:0] adc_sample, proc_sample, recorder_sample;
   logic [7:0] din_phys, din_out, aux_req, aux_out;
   logic [1:0] trip_req, trip_out;
   int bad_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #50 clk = ~clk;
   oscillogram_playback_sim #(.HOLDOFF_CYCLES(HO)) oscillogram_playback_sim_i (.CLK(clk),
      .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq),
      .REC_WR_VALID(rec_valid), .REC_WR_READY(rec_ready), .REC_WR_DATA(rec_data),
      .REC_WR_LAST(rec_last), .REC_WR_UPLOAD(rec_upload), .REC_WR_TIME(rec_time),
      .RTC_TIME(rtc_time), .SIM_MODE_ENTRY_IN(ctl[0]), .PLAYBACK_START_IN(ctl[1]),
      .SIM_CANCEL_IN(ctl[2]), .ADC_VALID(adc_valid), .ADC_SAMPLE(adc_sample),
      .PROC_VALID(proc_valid), .PROC_SAMPLE(proc_sample), .RECORDER_VALID(recorder_valid),
      .RECORDER_SAMPLE(recorder_sample), .DIN_PHYS(din_phys), .DIN_OUT(din_out),
      .TRIP_CLOSE_REQ(trip_req), .TRIP_CLOSE_OUT(trip_out), .AUX_REQ(aux_req),
      .AUX_OUT(aux_out), .RECORD_LOADED_OUT(loaded), .SIM_MODE_ACTIVE_OUT(sim),
      .PLAYBACK_STARTED_OUT(pb));
   osc_host_model osc_host_model_i (.clk(clk), .ready(rec_ready), .valid(rec_valid),
      .data(rec_data), .last(rec_last), .upload(rec_upload), .rec_time(rec_time));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rd);
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      ctl[k] <= 1'b1;
      @(posedge clk);
      ctl[k] <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic play(input int i);
      @(posedge clk);
      adc_valid <= 1'b1;
      adc_sample <= 16'hAA00 + 16'(i);
      @(posedge clk);
      adc_valid <= 1'b0;
      @(negedge clk);
      chk("recorder", 16'hAA00 + 16'(i), recorder_sample);
      @(negedge clk);
      chk("proc valid", 1'b1, proc_valid);
      chk("proc sample", 16'h1000 + 16'(i), proc_sample);
   endtask
   task automatic t_reset;
      rdchk("settings", OFS_SETTINGS, 32'h0000_0000);
      rdchk("state", OFS_STATE, 32'h0000_0000);
      rdchk("unmapped", 5'h1C, 32'h0000_0000);
      avs_byteenable <= 4'h0;
      bus(1'b1, OFS_SETTINGS, 32'h0000_001F);
      avs_byteenable <= 4'hF;
      rdchk("lane off", OFS_SETTINGS, 32'h0000_0000);
      pulse(1);
      pulse(2);
      tick(3);
      chk("idle start", 1'b0, pb);
      chk("idle din", 8'h5A, din_out);
      chk("idle trip", 2'h3, trip_out);
      chk("idle aux", 8'h81, aux_out);
      $display("reset test done");
   endtask
   task automatic t_upload;
      osc_host_model_i.send(4, 1'b1, 32'h0000_1234, 0);
      tick(3);
      chk("mode", 1'b1, sim);
      chk("loaded", 1'b1, loaded);
      rdchk("length", OFS_REC_LEN, 32'h0000_0004);
      rdchk("rec time", OFS_REC_TIME, 32'h0000_1234);
      rdchk("status", OFS_EVT_STATUS, 32'h0000_0001);
      chk("irq masked", 1'b0, irq);
      bus(1'b1, OFS_EVT_ENABLE, 32'h0000_0001);
      tick(1);
      chk("irq", 1'b1, irq);
      bus(1'b1, OFS_EVT_CLEAR, 32'h0000_0001);
      tick(1);
      chk("irq cleared", 1'b0, irq);
      pulse(1);
      tick(3);
      chk("no dig trig", 1'b0, pb);
      chk("still mode", 1'b1, sim);
      pulse(2);
      tick(3);
      chk("cancel", 1'b0, sim);
      rdchk("exit event", OFS_EVT_STATUS, 32'h0000_0008);
      $display("upload test done");
   endtask
   task automatic t_playback;
      bus(1'b1, OFS_SETTINGS, 32'h0000_0005);
      rdchk("settings", OFS_SETTINGS, 32'h0000_0005);
      pulse(1);
      tick(3);
      chk("start idle", 1'b0, pb);
      pulse(0);
      tick(3);
      chk("reentry", 1'b1, sim);
      pulse(1);
      tick(3);
      chk("playing", 1'b1, pb);
      chk("trip mask", 2'h0, trip_out);
      chk("aux mask", 8'h00, aux_out);
      for (int i = 0; i < 4; i++) begin
         play(i);
         tick(2);
         chk("din sim", (i < 3) ? 8'hC0 + 8'(i) : 8'h5A, din_out);
      end
      chk("holdoff", 1'b0, pb);
      chk("held", 1'b1, sim);
      tick(HO + 4);
      chk("auto exit", 1'b0, sim);
      $display("playback test done");
   endtask
   task automatic t_time;
      osc_host_model_i.send(3, 1'b0, 32'h0000_0077, 2);
      tick(3);
      chk("capture", 1'b0, sim);
      rdchk("length", OFS_REC_LEN, 32'h0000_0003);
      bus(1'b1, OFS_SETTINGS, 32'h0000_001A);
      pulse(0);
      tick(3);
      chk("entry", 1'b1, sim);
      pulse(1);
      tick(3);
      chk("no start", 1'b0, pb);
      @(posedge clk);
      rtc_time <= 32'h0000_0077;
      tick(3);
      chk("time start", 1'b1, pb);
      chk("trip on", 2'h3, trip_out);
      chk("aux on", 8'h81, aux_out);
      pulse(2);
      tick(3);
      chk("cancel play", 1'b0, sim);
      $display("time trigger test done");
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         $display("BAD timeout expected done seen hang");
         report_and_stop;
      end
   end
   initial begin
      rst_n = 1'b0;
      {avs_read, avs_write, adc_valid} = 3'h0;
      avs_address = 5'h00;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      rtc_time = 32'h0000_0000;
      ctl = 3'h0;
      adc_sample = 16'h0000;
      din_phys = 8'h5A;
      trip_req = 2'h3;
      aux_req = 8'h81;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_upload;
      t_playback;
      t_time;
      report_and_stop;
   end
endmodule
`default_nettype wire
